// ---- dv/tb_dmpd_top.sv ----
// Self-checking testbench for the pad pull-down and input volume block.
// Assumes a zero-wait APB slave; the bench drives every port itself.
`timescale 1ns/1ps
module tb_dmpd_top
    import dmpd_pkg::*;
;
    // ==========================================================
    // Signals and tables
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic mic_path_a_enable = 0, mic_path_b_enable = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, mic_data_pad_a_pulldown, mic_data_pad_b_pulldown;
    dmpd_gain_s input_gain;
    int errors = 0, check_count = 0, cyc = 0;
    localparam logic [15:0] A_PAD = 16'({DMPD_IDX_PAD_PULLDOWN, 2'b00});
    localparam logic [15:0] A_VOL = 16'({DMPD_IDX_INPUT_VOLUME, 2'b00});
    localparam logic [15:0] A_ST = 16'({DMPD_IDX_STATUS, 2'b00});
    logic [7:0] vc [7] = '{8'h00, 8'h2F, 8'h80, 8'h81, 8'hBF, 8'hC0, 8'hFF};
    logic [8:0] vg [7] = '{9'h080, 9'h0AF, 9'h000, 9'h001, 9'h03F, 9'h13F, 9'h13F};

    always #10 clk = ~clk;

    dmpd_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mic_path_a_enable(mic_path_a_enable),
        .mic_path_b_enable(mic_path_b_enable),
        .mic_data_pad_a_pulldown(mic_data_pad_a_pulldown),
        .mic_data_pad_b_pulldown(mic_data_pad_b_pulldown), .input_gain(input_gain));

    // ==========================================================
    // Tasks
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic settle();
        @(posedge clk);
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            results();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        apb(0, A_PAD, 32'h0, 4'hF);
        chk("pad reg reset", 32'h0000_0000, rd);
        apb(0, A_VOL, 32'h0, 4'hF);
        chk("volume reset", 32'h0000_0080, rd);
        chk("gain reset", 32'h0000_0000, 32'(input_gain));
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            apb(1, A_VOL, 32'(vc[i]), 4'hF);
            settle();
            chk("gain", 32'(vg[i]), 32'(input_gain));
            apb(0, A_ST, 32'h0, 4'hF);
            chk("status", {16'h0000, vg[i][7:0], 5'h00, vg[i][8], 2'b00}, rd);
        end
        $display("test volume done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            mic_path_a_enable <= i[2];
            mic_path_b_enable <= i[3];
            apb(1, A_PAD, 32'(i[1:0]), 4'hF);
            settle();
            chk("pad a", 32'(i[0] & i[2]), 32'(mic_data_pad_a_pulldown));
            chk("pad b", 32'(i[1] & i[3]), 32'(mic_data_pad_b_pulldown));
            apb(0, A_PAD, 32'h0, 4'hF);
            chk("pad reg", 32'(i[1:0]), rd);
            apb(0, A_ST, 32'h0, 4'hF);
            chk("status pads", 32'({i[1] & i[3], i[0] & i[2]}), 32'(rd[1:0]));
        end
        $display("test pads done");
        apb(1, A_PAD, 32'h0, 4'h0);
        apb(0, A_PAD, 32'h0, 4'hF);
        chk("strobe off", 32'h0000_0003, rd);
        apb(0, 16'h3000, 32'h0, 4'hF);
        chk("unmapped err", 32'h0000_0001, 32'(err));
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1, A_ST, 32'hFFFF_FFFF, 4'hF);
        chk("status write err", 32'h0000_0000, 32'(err));
        chk("ready", 32'h0000_0001, 32'(pready));
        apb(0, A_VOL, 32'h0, 4'hF);
        chk("volume kept", 32'h0000_00FF, rd);
        @(posedge clk);
        rst <= 1;
        settle();
        chk("pad a in reset", 32'h0, 32'(mic_data_pad_a_pulldown));
        chk("pad b in reset", 32'h0, 32'(mic_data_pad_b_pulldown));
        @(posedge clk);
        rst <= 0;
        apb(0, A_PAD, 32'h0, 4'hF);
        chk("pad reg after reset", 32'h0000_0000, rd);
        $display("test awkward done");
        results();
    end
endmodule

// ---- inc/dmpd_pkg.sv ----
// Package for the microphone pad pull-down and input volume block.
// Assumes one 50 MHz clock and an APB register bus with 32-bit data.
package dmpd_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [11:0] DMPD_IDX_PAD_PULLDOWN = 12'hC22;
    localparam logic [11:0] DMPD_IDX_INPUT_VOLUME = 12'hC30;
    localparam logic [11:0] DMPD_IDX_STATUS = 12'hC31;

    // ==========================================================
    // Field positions
    localparam int DMPD_POS_PAD_A_PD = 0;
    localparam int DMPD_POS_PAD_B_PD = 1;
    localparam int DMPD_POS_VOL_LSB = 0;
    localparam int DMPD_POS_ST_PAD_A = 0;
    localparam int DMPD_POS_ST_PAD_B = 1;
    localparam int DMPD_POS_ST_RSVD = 2;
    localparam int DMPD_POS_ST_GAIN_LSB = 8;

    // ==========================================================
    // Reset values and volume coding
    localparam logic [15:0] DMPD_RST_PAD_PULLDOWN = 16'h0000;
    localparam logic [7:0] DMPD_RST_INPUT_VOLUME = 8'h80;
    localparam logic [7:0] DMPD_VOL_MAX_CODE = 8'hBF;
    localparam logic [7:0] DMPD_VOL_ZERO_DB_CODE = 8'h80;

    typedef struct packed {
        logic pad_b_pulldown_enable;
        logic pad_a_pulldown_enable;
    } dmpd_pad_ctrl_s;

    typedef struct packed {
        logic reserved_code;
        logic signed [7:0] gain_half_db;
    } dmpd_gain_s;

endpackage

// ---- rtl/dmpd_top.sv ----
// Pad pull-down control and input volume decode, APB slave.
// Assumes all inputs synchronous to clk; pad cells hold the resistors.
// Pad drive and volume decode are registered: one clock of latency.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

// Contract
// - Volume code decodes to code times 0.5 dB minus 64 dB; above BFh reserved.
// - Each data pad has its own pull-down enable, independent of the other.
// - Pull-down is off whenever the pad's microphone input path is disabled; here the registered drive drops one clock after the path is disabled.
// - Pad B enable at bit 1, pad A at bit 0; reset 0, one enables.
// - Internal pull-downs exist on exactly the two microphone data pads.
module dmpd_top
    import dmpd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mic_path_a_enable,
    input wire logic mic_path_b_enable,
    output logic mic_data_pad_a_pulldown,
    output logic mic_data_pad_b_pulldown,
    output dmpd_gain_s input_gain
);

    // ==========================================================
    // Decode helpers
    function automatic dmpd_gain_s decode_gain(input logic [7:0] code);
        dmpd_gain_s g;
        logic [7:0] c;
        c = (code > DMPD_VOL_MAX_CODE) ? DMPD_VOL_MAX_CODE : code;
        g.gain_half_db = $signed(c - DMPD_VOL_ZERO_DB_CODE);
        g.reserved_code = (code > DMPD_VOL_MAX_CODE);
        return g;
    endfunction

    function automatic logic addr_hit(input logic [15:0] a, input logic [11:0] idx);
        return (a[15:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
    endfunction

    // ==========================================================
    // Bus decode
    logic setup_ph;
    logic access_ph;
    logic hit_pad;
    logic hit_vol;
    logic hit_st;
    logic mapped;
    dmpd_pad_ctrl_s pad_ctrl;
    logic [7:0] vol_code;
    logic [31:0] next_rdata;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_pad = addr_hit(paddr, DMPD_IDX_PAD_PULLDOWN);
    assign hit_vol = addr_hit(paddr, DMPD_IDX_INPUT_VOLUME);
    assign hit_st = addr_hit(paddr, DMPD_IDX_STATUS);
    assign mapped = hit_pad || hit_vol || hit_st;
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;

    // ==========================================================
    // Control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_ctrl <= dmpd_pad_ctrl_s'(DMPD_RST_PAD_PULLDOWN[1:0]);
        end else if (access_ph && pwrite && hit_pad && pstrb[0]) begin
            pad_ctrl.pad_a_pulldown_enable <= pwdata[DMPD_POS_PAD_A_PD];
            pad_ctrl.pad_b_pulldown_enable <= pwdata[DMPD_POS_PAD_B_PD];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vol_code <= DMPD_RST_INPUT_VOLUME;
        end else if (access_ph && pwrite && hit_vol && pstrb[0]) begin
            vol_code <= pwdata[DMPD_POS_VOL_LSB +: 8];
        end
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_pad) begin
            next_rdata[DMPD_POS_PAD_A_PD] = pad_ctrl.pad_a_pulldown_enable;
            next_rdata[DMPD_POS_PAD_B_PD] = pad_ctrl.pad_b_pulldown_enable;
        end else if (hit_vol) begin
            next_rdata[DMPD_POS_VOL_LSB +: 8] = vol_code;
        end else if (hit_st) begin
            next_rdata[DMPD_POS_ST_PAD_A] = mic_data_pad_a_pulldown;
            next_rdata[DMPD_POS_ST_PAD_B] = mic_data_pad_b_pulldown;
            next_rdata[DMPD_POS_ST_RSVD] = input_gain.reserved_code;
            next_rdata[DMPD_POS_ST_GAIN_LSB +: 8] = input_gain.gain_half_db;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // ==========================================================
    // Pad pull-down drive, one per microphone data pad
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mic_data_pad_a_pulldown <= 1'b0;
            mic_data_pad_b_pulldown <= 1'b0;
        end else begin
            mic_data_pad_a_pulldown <= pad_ctrl.pad_a_pulldown_enable
                && mic_path_a_enable;
            mic_data_pad_b_pulldown <= pad_ctrl.pad_b_pulldown_enable
                && mic_path_b_enable;
        end
    end

    // ==========================================================
    // Volume decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_gain <= decode_gain(DMPD_RST_INPUT_VOLUME);
        end else begin
            input_gain <= decode_gain(vol_code);
        end
    end

    // ==========================================================
    // Checks
    logic [8:0] chk_half_db;

    // Volume code one edge back, in half-dB steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chk_half_db <= 9'h000;
        end else begin
            chk_half_db <= {1'b0, vol_code} - {1'b0, DMPD_VOL_ZERO_DB_CODE};
        end
    end

    gain_value_a: assert property (
        @(posedge clk) disable iff (rst)
        ($past(vol_code) <= 8'hBF && !$past(rst))
            |-> (input_gain.gain_half_db == $signed(chk_half_db[7:0])
                && !input_gain.reserved_code))
        else $error("gain decode does not match volume code");

    gain_reserved_a: assert property (
        @(posedge clk) disable iff (rst)
        ($past(vol_code) > 8'hBF && !$past(rst))
            |-> (input_gain.reserved_code && input_gain.gain_half_db == 8'sd63))
        else $error("reserved volume code not flagged or not held at max");

    pad_indep_a: assert property (
        @(posedge clk) disable iff (rst)
        (access_ph && pwrite && hit_pad && pstrb[0])
            |=> (pad_ctrl.pad_a_pulldown_enable == $past(pwdata[0])
                && pad_ctrl.pad_b_pulldown_enable == $past(pwdata[1])))
        else $error("pad enables not written independently");

    path_off_a: assert property (
        @(posedge clk) disable iff (rst)
        (!mic_path_a_enable ##1 1'b1) |-> !mic_data_pad_a_pulldown)
        else $error("pad A pull-down active with path disabled");

    path_off_b_a: assert property (
        @(posedge clk) disable iff (rst)
        !$past(mic_path_b_enable) |-> !mic_data_pad_b_pulldown)
        else $error("pad B pull-down active with path disabled");

    pad_readback_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup_ph && !pwrite && hit_pad)
            |=> (prdata[1:0] == {pad_ctrl.pad_b_pulldown_enable,
                pad_ctrl.pad_a_pulldown_enable} && prdata[31:2] == 30'h0))
        else $error("pad control readback wrong");

    pd_and_a: assert property (
        @(posedge clk) disable iff (rst)
        (pad_ctrl.pad_b_pulldown_enable && mic_path_b_enable)
            |=> mic_data_pad_b_pulldown)
        else $error("pad B pull-down not applied within one cycle");

    pd_stable_a: assert property (
        @(posedge clk) disable iff (rst)
        (pad_ctrl.pad_a_pulldown_enable && mic_path_a_enable) [*2]
            |-> mic_data_pad_a_pulldown)
        else $error("pad A pull-down dropped while enabled");

    // ==========================================================
    // Checks on pad drive and register state
    pd_a_and_a: assert property (
        @(posedge clk) disable iff (rst)
        (pad_ctrl.pad_a_pulldown_enable && mic_path_a_enable)
            |=> mic_data_pad_a_pulldown)
        else $error("pad A pull-down not applied within one cycle");

    pd_b_stable_a: assert property (
        @(posedge clk) disable iff (rst)
        (pad_ctrl.pad_b_pulldown_enable && mic_path_b_enable) [*2]
            |-> mic_data_pad_b_pulldown)
        else $error("pad B pull-down dropped while enabled");

    pd_a_only_a: assert property (
        @(posedge clk) disable iff (rst)
        mic_data_pad_a_pulldown
            |-> ($past(pad_ctrl.pad_a_pulldown_enable) && $past(mic_path_a_enable)))
        else $error("pad A pull-down active without enable and path");

    pd_b_only_a: assert property (
        @(posedge clk) disable iff (rst)
        mic_data_pad_b_pulldown
            |-> ($past(pad_ctrl.pad_b_pulldown_enable) && $past(mic_path_b_enable)))
        else $error("pad B pull-down active without enable and path");

    pd_a_off_a: assert property (
        @(posedge clk) disable iff (rst)
        (!pad_ctrl.pad_a_pulldown_enable ##1 1'b1)
            |-> !mic_data_pad_a_pulldown)
        else $error("pad A pull-down active with enable clear");

    pd_b_off_a: assert property (
        @(posedge clk) disable iff (rst)
        (!pad_ctrl.pad_b_pulldown_enable ##1 1'b1)
            |-> !mic_data_pad_b_pulldown)
        else $error("pad B pull-down active with enable clear");

    pad_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !(access_ph && pwrite && hit_pad && pstrb[0]) |=> $stable(pad_ctrl))
        else $error("pad enables changed without a write");

    vol_write_a: assert property (
        @(posedge clk) disable iff (rst)
        (access_ph && pwrite && hit_vol && pstrb[0])
            |=> (vol_code == $past(pwdata[7:0])))
        else $error("volume code write lost");

    vol_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !(access_ph && pwrite && hit_vol && pstrb[0]) |=> $stable(vol_code))
        else $error("volume code changed without a write");

    gain_cap_a: assert property (
        @(posedge clk) disable iff (rst)
        input_gain.reserved_code |-> (input_gain.gain_half_db == 8'sd63))
        else $error("reserved code gain not at maximum");

    // ==========================================================
    // Checks on read data and bus answers
    rd_volume_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup_ph && !pwrite && hit_vol)
            |=> (prdata == {24'h000000, $past(vol_code)}))
        else $error("volume readback wrong");

    rd_status_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup_ph && !pwrite && hit_st)
            |=> (prdata[15:8] == $past(input_gain.gain_half_db)
                && prdata[2] == $past(input_gain.reserved_code)
                && prdata[1] == $past(mic_data_pad_b_pulldown)
                && prdata[0] == $past(mic_data_pad_a_pulldown)
                && prdata[31:16] == 16'h0000 && prdata[7:3] == 5'h00))
        else $error("status readback wrong");

    rd_unmapped_a: assert property (
        @(posedge clk) disable iff (rst)
        (setup_ph && !pwrite && !mapped) |=> (prdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    rd_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !(setup_ph && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read");

    err_nowrite_a: assert property (
        @(posedge clk) disable iff (rst)
        pslverr |=> ($stable(pad_ctrl) && $stable(vol_code)))
        else $error("refused access changed a register");

    err_flag_a: assert property (
        @(posedge clk) disable iff (rst)
        (access_ph && !mapped) |-> pslverr)
        else $error("unmapped access not refused");

    setup_err_a: assert property (
        @(posedge clk) disable iff (rst)
        setup_ph |-> !pslverr)
        else $error("error flagged outside the access phase");

    wr_status_a: assert property (
        @(posedge clk) disable iff (rst)
        (access_ph && pwrite && hit_st) |-> !pslverr)
        else $error("status write flagged as error");

endmodule
